// ---- hw/csic_params.svh ----
// offsets, field positions, reset values and timing counts of the stage input block
`ifndef CSIC_PARAMS_SVH
`define CSIC_PARAMS_SVH

// register map, word addresses on the register port
`define CSIC_PWR_CTRL_ADDR   10'h000
`define CSIC_RAW_RESULT_ADDR 10'h00B
`define CSIC_ROUTE_PAGE      5'h04
`define CSIC_RESULT_PAGE     6'h0E

// power control fields
`define CSIC_MODE_LSB        0
`define CSIC_SLEEP_LSB       2
`define CSIC_MODE_RST        2'h1
`define CSIC_SLEEP_RST       2'h0
`define CSIC_MODE_FULL       2'h0
`define CSIC_MODE_LOW        2'h2

// stage routing fields
`define CSIC_TYPE_LSB        12
`define CSIC_ROUTE_RST       16'hFFFF
`define CSIC_RESULT_RST      16'h0000
`define CSIC_PIN_FLOAT       2'h0
`define CSIC_PIN_NEG         2'h1
`define CSIC_PIN_POS         2'h2
`define CSIC_PIN_BIAS        2'h3
`define CSIC_TYPE_DIFF       2'h3
`define CSIC_LOW_PINS        7
`define CSIC_NUM_PINS        13
`define CSIC_NUM_STAGES      12
`define CSIC_LAST_STAGE      4'hB

// wake-up timing
`define CSIC_CLK_HZ          10000000
`define CSIC_SLEEP_STEP_MS   200
`define CSIC_SLEEP_STEP_CYC  (`CSIC_SLEEP_STEP_MS * (`CSIC_CLK_HZ / 1000))

`endif

// ---- hw/csic_pkg.sv ----
// types of the stage input block
package csic_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_ROUTE,
    ST_CONV,
    ST_SLEEP
  } csic_state_t;

  typedef enum logic [1:0] {
    RD_NONE,
    RD_HOLD,
    RD_ROUTE,
    RD_RESULT
  } csic_rd_t;

  typedef struct packed {
    csic_state_t state;
    logic [3:0]  stage;
    logic [23:0] sleep_cnt;
    logic [1:0]  mode;
    logic [1:0]  sleep_sel;
    logic [15:0] raw;
    csic_rd_t    rd_kind;
    logic        rd_half;
    logic [15:0] rd_val;
    logic        conv_start;
    logic [3:0]  conv_stage;
    logic [12:0] pin_pos;
    logic [12:0] pin_neg;
    logic [12:0] pin_bias;
    logic [1:0]  conn_type;
    logic        conv_diff;
  } csic_regs_t;

endpackage

// ---- hw/csic_mem.sv ----
// small register memory with lane writes and two registered read ports
`timescale 1ns/1ps
module csic_mem #(
  parameter int          LANES = 1,
  parameter int          DEPTH = 12,
  parameter logic [15:0] RST   = 16'h0000
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_b,
  input  wire logic [LANES-1:0]     we,
  input  wire logic [3:0]           waddr,
  input  wire logic [16*LANES-1:0]  wdata,
  input  wire logic [3:0]           raddr_a,
  output logic      [16*LANES-1:0]  rdata_a_reg,
  input  wire logic [3:0]           raddr_b,
  output logic      [16*LANES-1:0]  rdata_b_reg
);

  logic [16*LANES-1:0] mem_reg [DEPTH];

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      for (int l = 0; l < LANES; l++) begin
        if (!rst_b) begin
          mem_reg[i][16*l +: 16] <= RST;
        end else if (we[l] && waddr == 4'(i)) begin
          mem_reg[i][16*l +: 16] <= wdata[16*l +: 16];
        end
      end
    end
    if (!rst_b) begin
      rdata_a_reg <= '0;
      rdata_b_reg <= '0;
    end else begin
      // out-of-range addresses read as zero
      rdata_a_reg <= (int'(raddr_a) < DEPTH) ? mem_reg[raddr_a] : '0;
      rdata_b_reg <= (int'(raddr_b) < DEPTH) ? mem_reg[raddr_b] : '0;
    end
  end

endmodule // csic_mem

// ---- hw/csic_stage_input.sv ----
// stage routing, wake-up sequencing and result registers of the sensing converter
`timescale 1ns/1ps
`include "csic_params.svh"

module csic_stage_input #(
  parameter int SLEEP_STEP_CYC = `CSIC_SLEEP_STEP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [9:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             conv_start,
  output logic      [3:0]  conv_stage,
  output logic      [12:0] pin_pos,
  output logic      [12:0] pin_neg,
  output logic      [12:0] pin_bias,
  output logic      [1:0]  conn_type,
  output logic             conv_diff,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data
);

  csic_pkg::csic_regs_t r_reg;
  csic_pkg::csic_regs_t r_next;

  logic [23:0] step_cyc;
  logic [23:0] sleep_load;
  logic        route_hit;
  logic        result_hit;
  logic [1:0]  route_we;
  logic        result_we;
  logic [31:0] route_host;
  logic [31:0] route_seq;
  logic [15:0] result_host;
  logic [25:0] pin_fields;
  logic [12:0] dec_pos;
  logic [12:0] dec_neg;
  logic [12:0] dec_bias;
  logic        seq_end;

  assign step_cyc   = 24'(SLEEP_STEP_CYC);
  // delay is (code + 1) steps; counter runs down to zero inclusive
  assign sleep_load = 24'(({22'h0, r_reg.sleep_sel} + 24'h1) * step_cyc - 24'h1);
  assign route_hit  = (reg_addr[9:5] == `CSIC_ROUTE_PAGE)
                      && (reg_addr[4:1] <= `CSIC_LAST_STAGE);
  assign result_hit = (reg_addr[9:4] == `CSIC_RESULT_PAGE)
                      && (reg_addr[3:0] <= `CSIC_LAST_STAGE);
  assign route_we   = {2{reg_wr && route_hit}} & {reg_addr[0], ~reg_addr[0]};
  assign result_we  = (r_reg.state == csic_pkg::ST_CONV) && conv_done;
  assign seq_end    = result_we && (r_reg.stage == `CSIC_LAST_STAGE);

  // routing store: one word per stage, low register in lane 0, high in lane 1
  csic_mem #(
    .LANES (2),
    .DEPTH (`CSIC_NUM_STAGES),
    .RST   (`CSIC_ROUTE_RST)
  ) u_route_mem (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .we          (route_we),
    .waddr       (reg_addr[4:1]),
    .wdata       ({reg_wdata, reg_wdata}),
    .raddr_a     (reg_addr[4:1]),
    .rdata_a_reg (route_host),
    .raddr_b     (r_reg.stage),
    .rdata_b_reg (route_seq)
  );

  // per-stage results for host processing
  csic_mem #(
    .LANES (1),
    .DEPTH (`CSIC_NUM_STAGES),
    .RST   (`CSIC_RESULT_RST)
  ) u_result_mem (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .we          (result_we),
    .waddr       (r_reg.stage),
    .wdata       (conv_data),
    .raddr_a     (reg_addr[3:0]),
    .rdata_a_reg (result_host),
    .raddr_b     (4'h0),
    .rdata_b_reg ()
  );

  // pins 0..6 sit in the low register, 7..12 in the high one
  assign pin_fields = {route_seq[27:16], route_seq[13:0]};

  genvar gp;
  generate
    for (gp = 0; gp < `CSIC_NUM_PINS; gp++) begin : g_pin
      assign dec_pos[gp]  = pin_fields[2*gp +: 2] == `CSIC_PIN_POS;
      assign dec_neg[gp]  = pin_fields[2*gp +: 2] == `CSIC_PIN_NEG;
      assign dec_bias[gp] = pin_fields[2*gp +: 2] == `CSIC_PIN_BIAS;
    end
  endgenerate

  always_comb begin
    r_next            = r_reg;
    r_next.conv_start = 1'b0;
    r_next.rd_kind    = csic_pkg::RD_NONE;

    // register port
    if (reg_wr && reg_addr == `CSIC_PWR_CTRL_ADDR) begin
      r_next.mode      = reg_wdata[`CSIC_MODE_LSB +: 2];
      r_next.sleep_sel = reg_wdata[`CSIC_SLEEP_LSB +: 2];
    end
    if (reg_rd) begin
      r_next.rd_half = reg_addr[0];
      if (reg_addr == `CSIC_PWR_CTRL_ADDR) begin
        r_next.rd_kind = csic_pkg::RD_HOLD;
        r_next.rd_val  = {12'h000, r_reg.sleep_sel, r_reg.mode};
      end else if (reg_addr == `CSIC_RAW_RESULT_ADDR) begin
        r_next.rd_kind = csic_pkg::RD_HOLD;
        r_next.rd_val  = r_reg.raw;
      end else if (route_hit) begin
        r_next.rd_kind = csic_pkg::RD_ROUTE;
      end else if (result_hit) begin
        r_next.rd_kind = csic_pkg::RD_RESULT;
      end else begin
        r_next.rd_kind = csic_pkg::RD_HOLD;
        r_next.rd_val  = 16'h0000;
      end
    end

    // conversion sequencer
    case (r_reg.state)
      csic_pkg::ST_IDLE: begin
        if (r_reg.mode == `CSIC_MODE_FULL || r_reg.mode == `CSIC_MODE_LOW) begin
          r_next.stage = 4'h0;
          r_next.state = csic_pkg::ST_FETCH;
        end
      end
      csic_pkg::ST_FETCH: begin
        r_next.state = csic_pkg::ST_ROUTE;
      end
      csic_pkg::ST_ROUTE: begin
        // new route applied together with the stage start
        r_next.pin_pos    = dec_pos;
        r_next.pin_neg    = dec_neg;
        r_next.pin_bias   = dec_bias;
        r_next.conn_type  = route_seq[16+`CSIC_TYPE_LSB +: 2];
        r_next.conv_diff  = route_seq[16+`CSIC_TYPE_LSB +: 2]
                            == `CSIC_TYPE_DIFF;
        r_next.conv_stage = r_reg.stage;
        r_next.conv_start = 1'b1;
        r_next.state      = csic_pkg::ST_CONV;
      end
      csic_pkg::ST_CONV: begin
        if (conv_done) begin
          // converter polarity follows the pos/neg routes as given
          r_next.raw = conv_data;
          if (r_reg.stage != `CSIC_LAST_STAGE) begin
            r_next.stage = r_reg.stage + 4'h1;
            r_next.state = (r_reg.mode == `CSIC_MODE_FULL || r_reg.mode == `CSIC_MODE_LOW)
                           ? csic_pkg::ST_FETCH : csic_pkg::ST_IDLE;
          end else if (r_reg.mode == `CSIC_MODE_LOW) begin
            r_next.sleep_cnt = sleep_load;
            r_next.state     = csic_pkg::ST_SLEEP;
          end else if (r_reg.mode == `CSIC_MODE_FULL) begin
            r_next.stage = 4'h0;
            r_next.state = csic_pkg::ST_FETCH;
          end else begin
            r_next.state = csic_pkg::ST_IDLE;
          end
        end
      end
      csic_pkg::ST_SLEEP: begin
        if (r_reg.mode != `CSIC_MODE_LOW) begin
          r_next.state = csic_pkg::ST_IDLE;
        end else if (r_reg.sleep_cnt == 24'h0) begin
          // period = sequence time + selected delay
          r_next.stage = 4'h0;
          r_next.state = csic_pkg::ST_FETCH;
        end else begin
          r_next.sleep_cnt = r_reg.sleep_cnt - 24'h1;
        end
      end
      default: begin
        r_next.state = csic_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      r_reg            <= '0;
      r_reg.state      <= csic_pkg::ST_IDLE;
      r_reg.mode       <= `CSIC_MODE_RST;
      r_reg.sleep_sel  <= `CSIC_SLEEP_RST;
      r_reg.rd_kind    <= csic_pkg::RD_NONE;
      r_reg.pin_bias   <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  always_comb begin
    case (r_reg.rd_kind)
      csic_pkg::RD_HOLD:   reg_rdata = r_reg.rd_val;
      csic_pkg::RD_ROUTE:  reg_rdata = r_reg.rd_half ? route_host[31:16] : route_host[15:0];
      csic_pkg::RD_RESULT: reg_rdata = result_host;
      default:             reg_rdata = 16'h0000;
    endcase
  end

  assign conv_start = r_reg.conv_start;
  assign conv_stage = r_reg.conv_stage;
  assign pin_pos    = r_reg.pin_pos;
  assign pin_neg    = r_reg.pin_neg;
  assign pin_bias   = r_reg.pin_bias;
  assign conn_type  = r_reg.conn_type;
  assign conv_diff  = r_reg.conv_diff;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_SLEEP_ENTER: assert property (
    seq_end && r_reg.mode == `CSIC_MODE_LOW |=> r_reg.state == csic_pkg::ST_SLEEP)
    else $error("low power sequence end did not enter sleep");

  AST_SLEEP_LOAD: assert property (
    seq_end && r_reg.mode == `CSIC_MODE_LOW
    |=> r_reg.sleep_cnt + 24'h1 == step_cyc * (24'($past(r_reg.sleep_sel)) + 24'h1))
    else $error("sleep delay does not match the selected code");

  AST_LONGEST: assert property (
    seq_end && r_reg.mode == `CSIC_MODE_LOW && r_reg.sleep_sel == 2'h3
    |=> r_reg.sleep_cnt == 24'(step_cyc * 24'h4 - 24'h1))
    else $error("longest code does not give four steps");

  AST_WAKE: assert property (
    r_reg.state == csic_pkg::ST_SLEEP && r_reg.mode == `CSIC_MODE_LOW && r_reg.sleep_cnt == 24'h0
    |=> r_reg.state == csic_pkg::ST_FETCH && r_reg.stage == 4'h0 ##2 conv_start)
    else $error("wake-up did not restart at the first stage");

  AST_SLEEP_RUN: assert property (
    r_reg.state == csic_pkg::ST_SLEEP && r_reg.mode == `CSIC_MODE_LOW && r_reg.sleep_cnt != 24'h0
    |=> r_reg.state == csic_pkg::ST_SLEEP && r_reg.sleep_cnt == $past(r_reg.sleep_cnt) - 24'h1)
    else $error("sleep counter did not step down");

  AST_RAW: assert property (
    result_we |=> r_reg.raw == $past(conv_data))
    else $error("raw result not captured");

  AST_RAW_READ: assert property (
    reg_rd && reg_addr == `CSIC_RAW_RESULT_ADDR |=> reg_rdata == $past(r_reg.raw))
    else $error("raw result read returned wrong data");

  AST_START: assert property (
    r_reg.state == csic_pkg::ST_FETCH |=> ##1 conv_start && conv_stage == $past(r_reg.stage, 2))
    else $error("stage start not issued two cycles after fetch");

  AST_EXCL: assert property (
    (pin_pos & pin_neg) == 13'h0 && (pin_pos & pin_bias) == 13'h0 && (pin_neg & pin_bias) == 13'h0)
    else $error("a pin is routed to more than one node");

  AST_TYPE: assert property (
    conv_start |-> conv_diff == (conn_type == `CSIC_TYPE_DIFF))
    else $error("differential flag disagrees with connection type");

  AST_NEXT_STAGE: assert property (
    result_we && r_reg.stage != `CSIC_LAST_STAGE && r_reg.mode == `CSIC_MODE_FULL
    |=> r_reg.stage == $past(r_reg.stage) + 4'h1)
    else $error("sequencer skipped a stage");

  AST_FETCH_ROUTE: assert property (
    r_reg.state == csic_pkg::ST_FETCH |=> r_reg.state == csic_pkg::ST_ROUTE)
    else $error("fetch did not move on to routing");

  AST_START_PULSE: assert property (
    conv_start |=> !conv_start)
    else $error("stage start lasted more than one cycle");

  AST_ROUTE_HOLD: assert property (
    !conv_start |-> $stable(pin_pos) && $stable(pin_neg) && $stable(pin_bias)
    && $stable(conn_type) && $stable(conv_stage))
    else $error("routes changed outside a stage start");

  AST_FULL_WRAP: assert property (
    seq_end && r_reg.mode == `CSIC_MODE_FULL
    |=> r_reg.state == csic_pkg::ST_FETCH && r_reg.stage == 4'h0)
    else $error("full power sequence did not restart at the first stage");

  AST_CONV_WAIT: assert property (
    r_reg.state == csic_pkg::ST_CONV && !conv_done |=> r_reg.state == csic_pkg::ST_CONV)
    else $error("stage left before the converter finished");

  AST_PWR_WRITE: assert property (
    reg_wr && reg_addr == `CSIC_PWR_CTRL_ADDR
    |=> r_reg.sleep_sel == $past(reg_wdata[3:2]))
    else $error("sleep select not taken from bits 3:2");

  AST_PWR_READ: assert property (
    reg_rd && reg_addr == `CSIC_PWR_CTRL_ADDR
    |=> reg_rdata[3:2] == $past(r_reg.sleep_sel) && reg_rdata[15:4] == 12'h000)
    else $error("power control read returned wrong sleep select");

  AST_TYPE_FIELD: assert property (
    conv_start |-> conn_type == $past(route_seq[29:28]))
    else $error("connection type not taken from high register bits 13:12");

  AST_PIN0_POS: assert property (
    conv_start |-> pin_pos[0] == ($past(route_seq[1:0]) == `CSIC_PIN_POS))
    else $error("pin zero positive route not decoded from its field");

  AST_PIN12_NEG: assert property (
    conv_start |-> pin_neg[12] == ($past(route_seq[27:26]) == `CSIC_PIN_NEG))
    else $error("pin twelve negative route not decoded from its field");

  AST_SLEEP_EXIT: assert property (
    r_reg.state == csic_pkg::ST_SLEEP && r_reg.mode != `CSIC_MODE_LOW
    |=> r_reg.state == csic_pkg::ST_IDLE)
    else $error("sleep went on after low power mode was left");

  COV_LOW_WAKE: cover property (r_reg.state == csic_pkg::ST_SLEEP ##1 r_reg.state == csic_pkg::ST_FETCH);
  COV_SEQ_END: cover property (seq_end);
  COV_DIFF: cover property (conv_start && conv_diff);
  COV_ROUTE_RD: cover property (reg_rd && route_hit);
  COV_LONG_SLEEP: cover property (
    seq_end && r_reg.mode == `CSIC_MODE_LOW && r_reg.sleep_sel == 2'h3);

endmodule // csic_stage_input

// ---- tb/csic_conv_model.sv ----
// converter and sensor model answering each stage start
`timescale 1ns/1ps
module csic_conv_model #(
  parameter int DELAY = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        conv_start,
  input  wire logic [12:0] pin_pos,
  input  wire logic [12:0] pin_neg,
  input  wire logic [12:0] touch,
  output logic             conv_done,
  output logic      [15:0] conv_data
);
  logic [7:0]  cnt;
  logic        busy;
  logic [15:0] val;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busy      <= 1'b0;
      cnt       <= 8'h00;
      val       <= 16'h8000;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      // data toggles while not valid
      conv_data <= ~conv_data;
      cnt       <= cnt + 8'h01;
      if (conv_start) begin
        busy <= 1'b1;
        cnt  <= 8'h00;
        val  <= 16'h8000 + 16'($countones(pin_pos & touch)) * 16'h0100
              - 16'($countones(pin_neg & touch)) * 16'h0100;
      end else if (busy && cnt == 8'(DELAY)) begin
        busy      <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= val;
      end
    end
  end
endmodule // csic_conv_model

// ---- tb/csic_stage_input_tb.sv ----
// testbench of the stage input block
`timescale 1ns/1ps
module csic_stage_input_tb;
  localparam int STEP = 20;
  // converter wait plus fetch, route and start cycles per stage
  localparam int STAGE_CYC = 9;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [9:0]  reg_addr = 10'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] conv_data;
  logic [15:0] rd_val;
  logic [12:0] pin_pos;
  logic [12:0] pin_neg;
  logic [12:0] pin_bias;
  logic [3:0]  conv_stage;
  logic [1:0]  conn_type;
  logic        conv_start;
  logic        conv_diff;
  logic        conv_done;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t0;
  int          p_full;

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  csic_stage_input #(.SLEEP_STEP_CYC(STEP)) u_csic_stage_input (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
    .conv_stage(conv_stage), .pin_pos(pin_pos), .pin_neg(pin_neg), .pin_bias(pin_bias),
    .conn_type(conn_type), .conv_diff(conv_diff), .conv_done(conv_done),
    .conv_data(conv_data));

  csic_conv_model u_csic_conv_model (
    .ref_clk(ref_clk), .rst_b(rst_b), .conv_start(conv_start), .pin_pos(pin_pos),
    .pin_neg(pin_neg), .touch(13'h1008), .conv_done(conv_done), .conv_data(conv_data));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic wait_start(input logic [3:0] s);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge ref_clk);
      #1;
      if (conv_start === 1'b1 && conv_stage === s) break;
    end
    check(16'(i < 2000), 16'h0001);
  endtask

  task automatic check_route(input logic [12:0] p, input logic [12:0] n,
                             input logic [12:0] b, input logic [1:0] t);
    check(16'(pin_pos), 16'(p));
    check(16'(pin_neg), 16'(n));
    check(16'(pin_bias), 16'(b));
    check(16'(conn_type), 16'(t));
    check(16'(conv_diff), 16'(t == 2'h3));
  endtask

  task automatic t_reset;
    check(16'(pin_bias), 16'h1FFF);
    rd(10'h000);
    check(rd_val, 16'h0001);
    rd(10'h080);
    check(rd_val, 16'hFFFF);
    rd(10'h0EB);
    check(rd_val, 16'h0000);
  endtask

  task automatic t_regs;
    wr(10'h080, 16'hFFBF);
    wr(10'h081, 16'h2FFF);
    wr(10'h082, 16'hFFFC);
    wr(10'h08A, 16'hFFFE);
    wr(10'h08B, 16'h37FF);
    rd(10'h081);
    check(rd_val, 16'h2FFF);
    rd(10'h08A);
    check(rd_val, 16'hFFFE);
    rd(10'h08B);
    check(rd_val, 16'h37FF);
    wr(10'h00B, 16'h1234);
    rd(10'h00B);
    check(rd_val, 16'h0000);
    wr(10'h3FF, 16'h5555);
    rd(10'h3FF);
    check(rd_val, 16'h0000);
  endtask

  task automatic t_full;
    wr(10'h000, 16'h0000);
    wait_start(4'h0);
    t0 = cyc;
    check_route(13'h0008, 13'h0000, 13'h1FF7, 2'h2);
    wait_start(4'h1);
    check_route(13'h0000, 13'h0000, 13'h1FFE, 2'h3);
    wait_start(4'h5);
    check_route(13'h0001, 13'h1000, 13'h0FFE, 2'h3);
    wait_start(4'h0);
    p_full = cyc - t0;
    check(16'(p_full), 16'(12 * STAGE_CYC));
    wait_start(4'h5);
    wr(10'h000, 16'h0001);
    repeat (20) @(posedge ref_clk);
    check(16'(conv_stage), 16'h0005);
    rd(10'h00B);
    check(rd_val, 16'h7F00);
    rd(10'h0E0);
    check(rd_val, 16'h8100);
    rd(10'h0E5);
    check(rd_val, 16'h7F00);
  endtask

  task automatic t_low;
    for (int c = 0; c < 4; c++) begin
      wr(10'h000, 16'hFFF2 | 16'(c * 4));
      rd(10'h000);
      check(rd_val, 16'(c * 4 + 2));
      wait_start(4'h0);
      t0 = cyc;
      wait_start(4'h0);
      check(16'(cyc - t0), 16'(p_full + (c + 1) * STEP));
      wr(10'h000, 16'h0001);
      repeat (20) @(posedge ref_clk);
    end
  endtask

  task automatic final_report;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset;
    t_regs;
    t_full;
    t_low;
    final_report;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    final_report;
  end
endmodule // csic_stage_input_tb
